// ===== logic/dac_port_map.vh
// field positions, mode codes and counts of the host serial/parallel port
`ifndef DAC_PORT_MAP_VH
`define DAC_PORT_MAP_VH

`define MODE_ACQ        2'h0
`define MODE_DAC        2'h1
`define MODE_ACQ_RB     2'h2
`define MODE_RB         2'h3

`define HDR_BITS        5'h0A
`define DAC_BITS        5'h18
`define RB_BITS         5'h0E

`define HDR_MODE_HI     9
`define HDR_MODE_LO     8
`define HDR_CAL         7
`define HDR_OFFS        6
`define HDR_TEST        5
`define HDR_ADDR_HI     4

`define CODE_W          14
`define OFFSET_CHAN     6'h20
`define NUM_CHAN        33
`define CODE_RESET      14'h0000

`define ST_IDLE         2'h0
`define ST_SHIFT_IN     2'h1
`define ST_SHIFT_OUT    2'h2
`define ST_DONE         2'h3

`endif

// ===== logic/dac_host_port.v
// host-facing serial and parallel control port with dac code registers
`timescale 1ns/1ns
// What this block does
// - first two serial bits pick mode: acquire, dac load, acquire+read, read
// - dac load frame is 24 bits msb first; host spaces loads 400 ns
// - other modes send a 10-bit header; after a read mode the next frame returns 14-bit code
// - dac load with broadcast bit loads all zeros or ones into the 32 channels, offset channel kept
// - acquire with broadcast bit makes all 32 channels acquire together
// - offset-select bit targets offset channel, address bits ignored
// - five-bit address, msb first, picks one of 32 channels
// - 14 code bits land in the dac register only in dac load mode
// - works with serial clock free-running or only in frames
// - frame-select fall clears bit count; later edges ignored until done
// - after the full count, serial clocks ignored until new frame fall
// - readback: first rising clock enables output, each rise drives a bit
// - readback output released on falling edge of fourteenth clock
// - data in sampled on falling clocks after frame fall; ignored on read
// - nothing shifts before a frame-select falling edge
// - strap low: parallel acquire-only interface, serial disabled
// - parallel: select shares frame pin; address taken at write rise
// - parallel offset select addresses offset channel, ignores address
// - parallel broadcast makes all 32 channels acquire together
`include "dac_port_map.vh"

module dac_host_port #(
  parameter CODE_W = `CODE_W
) (
  // clock, reset, enable
  input  wire                ref_clk,
  input  wire                rst,
  input  wire                clk_en,
  // pins from the host
  input  wire                interface_select_strap,
  input  wire                frame_sel_n,
  input  wire                sclk,
  input  wire                sdin,
  output wire                sdout,
  output wire                sdout_oe_n,
  input  wire                wr_n,
  input  wire [4:0]          channel_address,
  input  wire                offset_sel,
  input  wire                broadcast,
  // command stream to the analog core
  output wire                cmd_valid,
  input  wire                cmd_ready,
  output wire [1:0]          cmd_mode,
  output wire [5:0]          cmd_channel,
  output wire                cmd_broadcast,
  output wire [CODE_W-1:0]   dac_code_bits,
  output wire                accept_ready,
  // acquisition results from the analog core
  input  wire                acq_wr,
  input  wire [5:0]          acq_chan,
  input  wire [CODE_W-1:0]   acq_code,
  // local register read port
  input  wire [5:0]          rd_chan,
  output reg  [CODE_W-1:0]   rd_code
);

  localparam ENT_W = 2 + 6 + 1 + CODE_W;

  // channel index from address and offset select
  function [5:0] chan_of;
    input       offs;
    input [4:0] addr;
    begin
      chan_of = offs ? `OFFSET_CHAN : {1'b0, addr};
    end
  endfunction

  // pin synchronisers: stage a is read only by stage b
  reg  [6:0] sync_a_reg;
  reg  [6:0] sync_b_reg;
  reg  [6:0] sync_c_reg;
  wire [6:0] pins_in;
  assign pins_in = {interface_select_strap, frame_sel_n, sclk, sdin, wr_n,
                    offset_sel, broadcast};

  always @(posedge ref_clk) begin
    if (rst) begin
      // sclk idles low, so it resets low: no false edge after reset
      sync_a_reg <= 7'h6F;
      sync_b_reg <= 7'h6F;
      sync_c_reg <= 7'h6F;
    end else if (clk_en) begin
      sync_a_reg <= pins_in;
      sync_b_reg <= sync_a_reg;
      sync_c_reg <= sync_b_reg;
    end
  end

  // address lines only matter at the write strobe; still synchronised
  reg [4:0] addr_a_reg;
  reg [4:0] addr_b_reg;
  always @(posedge ref_clk) begin
    if (rst) begin
      addr_a_reg <= 5'h00;
      addr_b_reg <= 5'h00;
    end else if (clk_en) begin
      addr_a_reg <= channel_address;
      addr_b_reg <= addr_a_reg;
    end
  end

  wire strap_s  = sync_b_reg[6];
  wire frame_s  = sync_b_reg[5];
  wire din_s    = sync_b_reg[3];
  wire offs_s   = sync_b_reg[1];
  wire bcast_s  = sync_b_reg[0];
  wire frame_fall = sync_c_reg[5] & ~frame_s;
  wire sclk_fall  = sync_c_reg[4] & ~sync_b_reg[4];
  wire sclk_rise  = ~sync_c_reg[4] & sync_b_reg[4];
  wire wr_rise    = ~sync_c_reg[2] & sync_b_reg[2];

  // dac code registers, index 32 is the offset channel
  reg [CODE_W-1:0] dac_mem [0:`NUM_CHAN-1];

  // serial engine
  reg  [1:0]        state_reg;
  reg  [4:0]        count_reg;
  reg  [23:0]       shift_reg;
  reg  [CODE_W-1:0] rb_shift_reg;
  reg               rb_pend_reg;
  reg  [5:0]        rb_chan_reg;
  reg               sdout_reg;
  reg               oe_n_reg;
  reg               push_reg;
  reg  [ENT_W-1:0]  push_data_reg;

  wire [23:0] shift_next = {shift_reg[22:0], din_s};
  wire [4:0]  count_next = count_reg + 5'h01;
  wire [9:0]  hdr10      = shift_next[9:0];
  wire [9:0]  hdr24      = shift_next[23:14];
  wire [1:0]  mode10     = {hdr10[`HDR_MODE_HI], hdr10[`HDR_MODE_LO]};
  wire        in_ready;

  assign sdout      = sdout_reg;
  assign sdout_oe_n = oe_n_reg;

  integer i;

  always @(posedge ref_clk) begin
    if (rst) begin
      state_reg     <= `ST_IDLE;
      count_reg     <= 5'h00;
      shift_reg     <= 24'h000000;
      rb_shift_reg  <= `CODE_RESET;
      rb_pend_reg   <= 1'b0;
      rb_chan_reg   <= 6'h00;
      sdout_reg     <= 1'b0;
      oe_n_reg      <= 1'b1;
      push_reg      <= 1'b0;
      push_data_reg <= {ENT_W{1'b0}};
      rd_code       <= `CODE_RESET;
      for (i = 0; i < `NUM_CHAN; i = i + 1) begin
        dac_mem[i] <= `CODE_RESET;
      end
    end else if (clk_en) begin
      push_reg <= 1'b0;
      rd_code  <= dac_mem[rd_chan];
      // analog core writes its converted code back
      if (acq_wr) begin
        dac_mem[acq_chan] <= acq_code;
      end
      if (strap_s == 1'b0) begin
        // serial side held idle while parallel selected
        state_reg   <= `ST_IDLE;
        oe_n_reg    <= 1'b1;
        rb_pend_reg <= 1'b0;
        // address taken at write strobe rise with select low
        if (wr_rise && !frame_s) begin
          push_reg      <= 1'b1;
          push_data_reg <= {`MODE_ACQ, chan_of(offs_s, addr_b_reg),
                            bcast_s, `CODE_RESET};
        end
      end else begin
        case (state_reg)
          `ST_IDLE, `ST_DONE: begin
            // sclk ignored here; only a frame fall restarts
            // free-running or gated sclk both harmless here
            if (frame_fall) begin
              count_reg <= 5'h00;
              if (rb_pend_reg) begin
                rb_shift_reg <= dac_mem[rb_chan_reg];
                state_reg    <= `ST_SHIFT_OUT;
              end else begin
                state_reg <= `ST_SHIFT_IN;
              end
            end
          end
          `ST_SHIFT_IN: begin
            // frame edges ignored until the count completes
            if (sclk_fall) begin
              shift_reg <= shift_next;
              count_reg <= count_next;
              if (count_next == `HDR_BITS && mode10 != `MODE_DAC) begin
                state_reg     <= `ST_DONE;
                rb_pend_reg   <= mode10[1];
                rb_chan_reg   <= chan_of(hdr10[`HDR_OFFS],
                                         hdr10[`HDR_ADDR_HI:0]);
                push_reg      <= ~mode10[1] | ~mode10[0];
                push_data_reg <= {mode10,
                                  chan_of(hdr10[`HDR_OFFS],
                                          hdr10[`HDR_ADDR_HI:0]),
                                  hdr10[`HDR_CAL], `CODE_RESET};
              end else if (count_next == `DAC_BITS) begin
                state_reg   <= `ST_DONE;
                rb_pend_reg <= 1'b0;
                // code only used in dac load mode
                if (hdr24[`HDR_CAL]) begin
                  // broadcast level follows code msb
                  for (i = 0; i < `NUM_CHAN - 1; i = i + 1) begin
                    dac_mem[i] <= {CODE_W{shift_next[CODE_W-1]}};
                  end
                end else begin
                  dac_mem[chan_of(hdr24[`HDR_OFFS],
                                  hdr24[`HDR_ADDR_HI:0])]
                    <= shift_next[CODE_W-1:0];
                end
                push_reg      <= 1'b1;
                push_data_reg <= {`MODE_DAC,
                                  chan_of(hdr24[`HDR_OFFS],
                                          hdr24[`HDR_ADDR_HI:0]),
                                  hdr24[`HDR_CAL], shift_next[CODE_W-1:0]};
              end
            end
          end
          `ST_SHIFT_OUT: begin
            // data in ignored during readback
            if (sclk_rise) begin
              oe_n_reg     <= 1'b0;
              sdout_reg    <= rb_shift_reg[CODE_W-1];
              rb_shift_reg <= {rb_shift_reg[CODE_W-2:0], 1'b0};
            end else if (sclk_fall) begin
              count_reg <= count_next;
              if (count_next == `RB_BITS) begin
                oe_n_reg    <= 1'b1;
                rb_pend_reg <= 1'b0;
                state_reg   <= `ST_DONE;
              end
            end
          end
          default: begin
            state_reg <= `ST_IDLE;
          end
        endcase
      end
    end
  end

  // two-entry command buffer; a word arriving while both slots are full is dropped
  reg  [ENT_W-1:0] slot0_reg;
  reg  [ENT_W-1:0] slot1_reg;
  reg              v0_reg;
  reg              v1_reg;
  wire             pop  = v0_reg & cmd_ready;
  wire             push = push_reg & in_ready;

  assign in_ready      = ~v1_reg;
  assign accept_ready  = ~v1_reg;
  assign cmd_valid     = v0_reg;
  assign cmd_mode      = slot0_reg[ENT_W-1:ENT_W-2];
  assign cmd_channel   = slot0_reg[ENT_W-3:CODE_W+1];
  assign cmd_broadcast = slot0_reg[CODE_W];
  assign dac_code_bits = slot0_reg[CODE_W-1:0];

  always @(posedge ref_clk) begin
    if (rst) begin
      slot0_reg <= {ENT_W{1'b0}};
      slot1_reg <= {ENT_W{1'b0}};
      v0_reg    <= 1'b0;
      v1_reg    <= 1'b0;
    end else if (clk_en) begin
      if (pop) begin
        if (v1_reg) begin
          slot0_reg <= slot1_reg;
          v1_reg    <= push;
          if (push) begin
            slot1_reg <= push_data_reg;
          end
        end else begin
          v0_reg <= push;
          if (push) begin
            slot0_reg <= push_data_reg;
          end
        end
      end else if (push) begin
        if (!v0_reg) begin
          slot0_reg <= push_data_reg;
          v0_reg    <= 1'b1;
        end else begin
          slot1_reg <= push_data_reg;
          v1_reg    <= 1'b1;
        end
      end
    end
  end

endmodule // dac_host_port

// ===== verification/serial_master.sv
// serial master model that frames traffic into the control port
`timescale 1ns/1ns
module serial_master (
  // serial pins
  output logic frame_sel_n,
  output logic sclk,
  output logic sdin,
  input  wire  sdout,
  input  wire  sdout_oe_n
);
  // released line shows a flipped value, never a held bit
  wire line = sdout_oe_n ? ~sdout : sdout;
  initial begin
    frame_sel_n = 1'h1;
    sclk = 1'h0; // still outside frames
    sdin = 1'h0;
  end
  task automatic sel(input logic v);
    frame_sel_n = v; // parallel select shares the pin
  endtask
  // n low bits of w, msb first; readback bits gathered into r
  task automatic xfer(input int n, input logic [23:0] w,
    output logic [13:0] r);
    frame_sel_n = 1'h0;
    #800;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'h1;
      sdin = w[i]; // launched on rise, msb first
      #400;
      r = {r[12:0], line};
      sclk = 1'h0;
      #400;
    end
    #800; // no clocks past the count
    frame_sel_n = 1'h1;
    sdin = ~sdin;
    #2400; // gap well over 400 ns
  endtask
  // 24-bit word with frame bounced mid-word, then surplus clocks
  task automatic xfer_bad(input logic [23:0] w);
    frame_sel_n = 1'h0;
    #800;
    for (int i = 23; i >= 0; i--) begin
      sclk = 1'h1;
      sdin = w[i];
      #400;
      sclk = 1'h0;
      if (i == 12) frame_sel_n = 1'h1;
      if (i == 11) frame_sel_n = 1'h0;
      #400;
    end
    for (int i = 0; i < 3; i++) begin
      sclk = 1'h1;
      sdin = 1'h1; // surplus clocks past the count
      #400;
      sclk = 1'h0;
      #400;
    end
    frame_sel_n = 1'h1;
    #2400;
  endtask
endmodule // serial_master

// ===== verification/dac_host_port_assertions.sv
// assertions on the host control port outputs
`timescale 1ns/1ns
`include "dac_port_map.vh"
module dac_host_port_assertions #(parameter CODE_W = `CODE_W) (
  // clock and reset
  input wire ref_clk, rst,
  // host pins
  input wire interface_select_strap, frame_sel_n, sdout_oe_n,
  // command stream
  input wire cmd_valid, cmd_ready, accept_ready,
  input wire [1:0] cmd_mode,
  input wire [5:0] cmd_channel,
  input wire [CODE_W-1:0] dac_code_bits
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_rb_on;
    $fell(sdout_oe_n);
  endsequence
  chk_reset_quiet: assert property (
    $fell(rst) |-> sdout_oe_n && !cmd_valid && accept_ready)
    else $error("port busy after reset");
  chk_par_no_read: assert property (
    !interface_select_strap && $past(interface_select_strap, 4) == 1'h0
    |-> sdout_oe_n) else $error("readback driven in parallel mode");
  chk_no_rb_cmd: assert property (
    cmd_valid |-> cmd_mode != `MODE_RB) else $error("readback mode pushed");
  chk_chan_range: assert property (
    cmd_valid |-> cmd_channel <= `OFFSET_CHAN) else $error("bad channel");
  chk_code_unused: assert property (
    cmd_valid && cmd_mode != `MODE_DAC |-> dac_code_bits == '0)
    else $error("code bits outside dac load");
  chk_head_hold: assert property (
    cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_channel)
    && $stable(dac_code_bits)) else $error("stalled command changed");
  chk_rb_in_frame: assert property (
    s_rb_on |-> !frame_sel_n) else $error("readback outside frame");
  chk_rb_hold: assert property (
    s_rb_on |=> !sdout_oe_n [*8]) else $error("readback dropped early");
  chk_rb_release: assert property (
    s_rb_on |-> ##[100:116] $rose(sdout_oe_n))
    else $error("readback not released at fourteenth clock");
endmodule // dac_host_port_assertions
bind dac_host_port dac_host_port_assertions #(.CODE_W(CODE_W)) chk_i (
  .ref_clk, .rst, .interface_select_strap, .frame_sel_n, .sdout_oe_n,
  .cmd_valid, .cmd_ready, .accept_ready, .cmd_mode, .cmd_channel,
  .dac_code_bits);

// ===== verification/tb_top.sv
// testbench for the host control port
`timescale 1ns/1ns
`include "dac_port_map.vh"
module tb_top;
  logic ref_clk = 1'h0, rst = 1'h1, clk_en = 1'h1, wr_n = 1'h1;
  logic interface_select_strap = 1'h1, offset_sel = 1'h0, broadcast = 1'h0;
  logic cmd_ready = 1'h0, acq_wr = 1'h0;
  logic [4:0] channel_address = 5'h00;
  logic [5:0] acq_chan = 6'h00, rd_chan = 6'h00;
  logic [13:0] acq_code = 14'h0000, r;
  wire frame_sel_n, sclk, sdin, sdout, sdout_oe_n;
  wire cmd_valid, cmd_broadcast, accept_ready;
  wire [1:0] cmd_mode;
  wire [5:0] cmd_channel;
  wire [13:0] dac_code_bits, rd_code;
  int err_count = 0, check_count = 0;
  always #50 ref_clk = ~ref_clk;
  serial_master m (.frame_sel_n, .sclk, .sdin, .sdout, .sdout_oe_n);
  dac_host_port uut (.ref_clk, .rst, .clk_en, .interface_select_strap,
    .frame_sel_n, .sclk, .sdin, .sdout, .sdout_oe_n, .wr_n,
    .channel_address, .offset_sel, .broadcast, .cmd_valid, .cmd_ready,
    .cmd_mode, .cmd_channel, .cmd_broadcast, .dac_code_bits, .accept_ready,
    .acq_wr, .acq_chan, .acq_code, .rd_chan, .rd_code);
  // broadcast and offset bits chosen per frame; test bit always 0
  function automatic logic [9:0] hdr(input logic [1:0] md, input logic bc,
    input logic offs, input logic [4:0] a);
    return {md, bc, offs, 1'h0, a};
  endfunction
  task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (err_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wait_cmd;
    for (int i = 0; i < 300; i++) begin
      @(negedge ref_clk);
      if (cmd_valid === 1'h1)
        return;
    end
    err_count++;
    $display("wrong value at %0t: command missing", $time);
    test_done;
  endtask
  task automatic pop;
    cmd_ready = 1'h1;
    @(negedge ref_clk);
    cmd_ready = 1'h0;
  endtask
  task automatic rd(input logic [5:0] c, input logic [13:0] e);
    rd_chan = c;
    repeat (2) @(negedge ref_clk);
    chk(rd_code, e);
  endtask
  task automatic t_dac(input logic [4:0] a, input logic [13:0] c);
    m.xfer(24, {hdr(`MODE_DAC, 1'h0, 1'h0, a), c}, r);
    wait_cmd;
    chk(cmd_mode, `MODE_DAC);
    chk(cmd_channel, a);
    chk(dac_code_bits, c);
    pop;
    rd({1'h0, a}, c);
  endtask
  task automatic t_rb(input logic [1:0] md, input logic [4:0] a,
    input logic [13:0] e);
    m.xfer(10, hdr(md, 1'h0, 1'h0, a), r);
    if (md == `MODE_ACQ_RB) begin
      wait_cmd;
      chk(cmd_mode, md);
      pop;
      acq_chan = {1'h0, a};
      acq_code = e;
      acq_wr = 1'h1;
      @(negedge ref_clk);
      acq_wr = 1'h0;
    end
    m.xfer(14, 24'h00AAAA, r); // data in is noise here
    chk(r, e);
  endtask
  task automatic t_glitch;
    m.xfer_bad({hdr(`MODE_DAC, 1'h0, 1'h0, 5'h02), 14'h0F0F});
    wait_cmd;
    chk(dac_code_bits, 14'h0F0F);
    pop;
    repeat (4) @(negedge ref_clk);
    chk(cmd_valid, 1'h0);
    rd(6'h02, 14'h0F0F);
  endtask
  task automatic t_bcast;
    m.xfer(24, {hdr(`MODE_DAC, 1'h0, 1'h1, 5'h1F), 14'h0555}, r);
    wait_cmd;
    chk(cmd_channel, `OFFSET_CHAN);
    pop;
    rd(6'h1F, 14'h0000);
    m.xfer(24, {hdr(`MODE_DAC, 1'h1, 1'h0, 5'h00), 14'h2000}, r);
    wait_cmd;
    chk(cmd_broadcast, 1'h1);
    pop;
    for (int i = 0; i < 32; i++)
      rd(i[5:0], 14'h3FFF);
    rd(`OFFSET_CHAN, 14'h0555);
    m.xfer(10, hdr(`MODE_ACQ, 1'h1, 1'h0, 5'h03), r);
    wait_cmd;
    chk({cmd_mode, cmd_broadcast}, {`MODE_ACQ, 1'h1});
    pop;
  endtask
  task automatic pwr(input logic [4:0] a, input logic o, input logic b);
    channel_address = a;
    offset_sel = o;
    broadcast = b;
    repeat (4) @(negedge ref_clk);
    wr_n = 1'h0;
    repeat (4) @(negedge ref_clk);
    wr_n = 1'h1;
    repeat (6) @(negedge ref_clk);
  endtask
  // receiver stalled for the three writes, so the buffer fills and refuses the third
  task automatic t_par;
    interface_select_strap = 1'h0;
    m.sel(1'h0);
    pwr(5'h01, 1'h0, 1'h1);
    pwr(5'h09, 1'h1, 1'h0);
    chk(accept_ready, 1'h0);
    pwr(5'h03, 1'h0, 1'h0);
    wait_cmd;
    chk({cmd_mode, cmd_broadcast}, {`MODE_ACQ, 1'h1});
    pop;
    wait_cmd;
    chk(cmd_channel, `OFFSET_CHAN);
    pop;
    repeat (10) @(negedge ref_clk);
    chk(cmd_valid, 1'h0);
    m.sel(1'h1);
  endtask
  initial begin
    repeat (5) @(negedge ref_clk);
    rst = 1'h0;
    repeat (4) @(negedge ref_clk);
    t_dac(5'h05, 14'h1234);
    t_rb(`MODE_RB, 5'h05, 14'h1234);
    t_glitch;
    t_bcast;
    t_rb(`MODE_ACQ_RB, 5'h07, 14'h0ABC);
    t_par;
    test_done;
  end
endmodule // tb_top
